// ===== rtl/fcdpwm_pkg.sv
// constants, register map and field layout of the fast counter dual pwm block
// ************************************************************
// Functional notes
// ************************************************************
package fcdpwm_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam int PSC_W  = 14;
   localparam int SYNC_N = 2;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_GEN    = 4'h1;
   localparam logic [ADDR_W-1:0] REG_DUTY_A = 4'h2;
   localparam logic [ADDR_W-1:0] REG_DUTY_B = 4'h3;
   localparam logic [ADDR_W-1:0] REG_TOP    = 4'h4;
   localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h5;
   localparam logic [ADDR_W-1:0] REG_FLAG   = 4'h6;
   localparam logic [ADDR_W-1:0] REG_MASK   = 4'h7;
   localparam logic [ADDR_W-1:0] REG_CFG    = 4'h8;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CC_CLR_TOP = 7;
   localparam int CC_PWM_A   = 6;
   localparam int CC_CODE_A  = 4;
   localparam int CC_DIV     = 0;
   localparam int GC_PWM_B   = 6;
   localparam int GC_CODE_B  = 4;
   localparam int GC_PSC_RST = 1;
   localparam int FL_MATCH_A = 6;
   localparam int FL_MATCH_B = 5;
   localparam int FL_WRAP    = 2;
   localparam int CF_FAST    = 0;
   localparam int CF_GIE     = 1;
   localparam int CF_LOCK    = 2;

   localparam logic [DATA_W-1:0] FL_BITS  = 8'h64;
   localparam logic [DATA_W-1:0] GEN_BITS = 8'h70;
   localparam logic [DATA_W-1:0] CFG_BITS = 8'h03;

   // ************************************************************
   // values
   // ************************************************************
   localparam logic [DATA_W-1:0] REG_RST  = 8'h00;
   localparam logic [DATA_W-1:0] TOP_RST  = 8'hFF;
   localparam logic [DATA_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] CNT_MAX  = 8'hFF;
   localparam logic [DATA_W-1:0] CNT_ONE  = 8'h01;
   localparam logic [1:0] ACT_OFF  = 2'h0;
   localparam logic [1:0] ACT_COMP = 2'h1;
   localparam logic [1:0] ACT_CLR  = 2'h2;
   localparam logic [1:0] ACT_SET  = 2'h3;
endpackage

// ===== rtl/fcdpwm_sync.sv
// two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module fcdpwm_sync
   import fcdpwm_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= '0;
         dout   <= '0;
      end
      else if (ce)
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

// ===== rtl/fcdpwm_presc.sv
// power-of-two tick divider for the counter
`timescale 1ns/1ps
module fcdpwm_presc
   import fcdpwm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   input  wire logic       src,
   input  wire logic       clr,
   input  wire logic [3:0] sel,
   output logic            tick
);
   logic [PSC_W-1:0] pcnt_q;
   logic [PSC_W-1:0] mask;

   // code 1 passes every source edge, code 15 one in 16384
   assign mask = (sel == 4'h0) ? '0 : ({PSC_W{1'b1}} >> (4'hF - sel));
   assign tick = src && (sel != 4'h0) && ((pcnt_q & mask) == mask);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         pcnt_q <= '0;
      else if (ce)
      begin
         if (clr)
            pcnt_q <= '0;
         else if (src)
            pcnt_q <= pcnt_q + 1'b1;
      end
   end
endmodule

// ===== rtl/fcdpwm_top.sv
// eight-bit counter with three compares, normal timer or dual complementary pwm
`timescale 1ns/1ps
module fcdpwm_top
   import fcdpwm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic              fast_periph_clock,
   input  wire logic              pll_lock_indicator,
   output logic                   pwm_out_a,
   output logic                   pwm_out_a_oe,
   output logic                   pwm_out_a_n,
   output logic                   pwm_out_a_n_oe,
   output logic                   pwm_out_b,
   output logic                   pwm_out_b_oe,
   output logic                   pwm_out_b_n,
   output logic                   pwm_out_b_n_oe,
   output logic                   irq_req
);
   // ************************************************************
   // declarations
   // ************************************************************
   logic [DATA_W-1:0] ctrl_q;
   logic [DATA_W-1:0] gen_q;
   logic [DATA_W-1:0] buf_a_q;
   logic [DATA_W-1:0] buf_b_q;
   logic [DATA_W-1:0] act_a_q;
   logic [DATA_W-1:0] act_b_q;
   logic [DATA_W-1:0] top_q;
   logic [DATA_W-1:0] mask_q;
   logic [DATA_W-1:0] cfg_q;
   logic [DATA_W-1:0] flags_q;
   logic [DATA_W-1:0] cnt_q;
   logic [DATA_W-1:0] cnt_d;
   logic [DATA_W-1:0] cnt_s1_q;
   logic [DATA_W-1:0] cnt_s2_q;
   logic [DATA_W-1:0] ev_s1_q;
   logic [DATA_W-1:0] ev_s2_q;
   logic [DATA_W-1:0] ev_now;
   logic [DATA_W-1:0] clr_mask;
   logic [1:0]        pin_s;
   logic              fclk_d_q;
   logic              fclk_edge;
   logic              tick_src;
   logic              tick;
   logic              psc_clr;
   logic              pwm_a;
   logic              pwm_b;
   logic              pwm_mode;
   logic              at_top;
   logic              at_max;
   logic              load;
   logic [1:0]        code_a;
   logic [1:0]        code_b;
   logic [3:0]        ch_a_d;
   logic [3:0]        ch_b_d;
   assign pwm_a    = ctrl_q[CC_PWM_A];
   assign pwm_b    = gen_q[GC_PWM_B];
   assign pwm_mode = pwm_a | pwm_b;
   assign code_a   = ctrl_q[CC_CODE_A +: 2];
   assign code_b   = gen_q[GC_CODE_B +: 2];
   assign at_top   = (cnt_q == top_q);
   assign at_max   = (cnt_q == CNT_MAX);

   // ************************************************************
   // fast clock pin and tick generation
   // ************************************************************
   // fast clock is sampled, so it must stay below a third of the system clock
   fcdpwm_sync #(.W(2)) u_sync
   (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .din   ({pll_lock_indicator, fast_periph_clock}),
      .dout  (pin_s)
   );

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         fclk_d_q <= 1'b0;
      else if (ce)
         fclk_d_q <= pin_s[0];
   end

   assign fclk_edge = pin_s[0] & ~fclk_d_q;
   assign tick_src  = cfg_q[CF_FAST] ? fclk_edge : 1'b1;
   assign psc_clr   = ce && wr_en && (addr == REG_GEN) && wr_data[GC_PSC_RST];

   fcdpwm_presc u_presc
   (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .src   (tick_src),
      .clr   (psc_clr),
      .sel   (ctrl_q[CC_DIV +: 4]),
      .tick  (tick)
   );

   // ************************************************************
   // counter
   // ************************************************************
   // a bus write to the count wins over the tick
   always_comb
   begin
      cnt_d = cnt_q;
      if (wr_en && (addr == REG_COUNT))
         cnt_d = wr_data;
      else if (tick)
      begin
         if (((pwm_mode || ctrl_q[CC_CLR_TOP]) && at_top) || at_max)
            cnt_d = CNT_ZERO;
         else
            cnt_d = cnt_q + CNT_ONE;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= CNT_ZERO;
      else if (ce)
         cnt_q <= cnt_d;
   end

   // ************************************************************
   // compare registers with pwm buffering
   // ************************************************************
   assign load = tick && at_top;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         buf_a_q <= REG_RST;
         act_a_q <= REG_RST;
      end
      else if (ce)
      begin
         if (wr_en && (addr == REG_DUTY_A))
            buf_a_q <= wr_data;
         if (!pwm_a && wr_en && (addr == REG_DUTY_A))
            act_a_q <= wr_data;
         else if (pwm_a && load)
            act_a_q <= buf_a_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         buf_b_q <= REG_RST;
         act_b_q <= REG_RST;
      end
      else if (ce)
      begin
         if (wr_en && (addr == REG_DUTY_B))
            buf_b_q <= wr_data;
         if (!pwm_b && wr_en && (addr == REG_DUTY_B))
            act_b_q <= wr_data;
         else if (pwm_b && load)
            act_b_q <= buf_b_q;
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_q <= REG_RST;
         gen_q  <= REG_RST;
         top_q  <= TOP_RST;
         mask_q <= REG_RST;
         cfg_q  <= REG_RST;
      end
      else if (ce && wr_en)
      begin
         unique case (addr)
            REG_CTRL: ctrl_q <= wr_data;
            REG_GEN:  gen_q  <= wr_data & GEN_BITS;
            REG_TOP:  top_q  <= wr_data;
            REG_MASK: mask_q <= wr_data & FL_BITS;
            REG_CFG:  cfg_q  <= wr_data & CFG_BITS;
            default:  ;
         endcase
      end
   end

   // ************************************************************
   // flags, delayed through a two-stage pipe
   // ************************************************************
   always_comb
   begin
      ev_now = REG_RST;
      ev_now[FL_MATCH_A] = tick && (cnt_q == act_a_q);
      ev_now[FL_MATCH_B] = tick && (cnt_q == act_b_q);
      ev_now[FL_WRAP]    = tick && (at_max || (pwm_mode && at_top));
   end
   assign clr_mask = (wr_en && (addr == REG_FLAG)) ? (wr_data & FL_BITS) : REG_RST;
   // the pipe mirrors the crossing delay seen by software
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ev_s1_q  <= REG_RST;
         ev_s2_q  <= REG_RST;
         cnt_s1_q <= CNT_ZERO;
         cnt_s2_q <= CNT_ZERO;
      end
      else if (ce)
      begin
         ev_s1_q  <= ev_now;
         ev_s2_q  <= ev_s1_q;
         cnt_s1_q <= cnt_q;
         cnt_s2_q <= cnt_s1_q;
      end
   end
   // a set arriving with a write-one clear survives
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         flags_q <= REG_RST;
      else if (ce)
         flags_q <= (flags_q & ~clr_mask) | ev_s2_q;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         irq_req <= 1'b0;
      else if (ce)
         irq_req <= cfg_q[CF_GIE] && |(flags_q & mask_q);
   end
   // ************************************************************
   // output stage
   // ************************************************************
   // returns {out, out_n, oe, oe_n}
   function automatic logic [3:0] chan_next(input logic pwm, input logic [1:0] code,
                                            input logic [DATA_W-1:0] cnt, input logic [DATA_W-1:0] duty,
                                            input logic [DATA_W-1:0] top, input logic tk, input logic cur);
      logic hi;
      logic o;
      logic oe;
      logic oe_n;
      hi   = (code == ACT_SET);
      o    = cur;
      oe   = (code != ACT_OFF);
      oe_n = 1'b0;
      if (pwm)
      begin
         oe_n = (code == ACT_COMP);
         if (duty == CNT_ZERO)
            o = hi;
         else if (duty == top)
            o = !hi;
         else if (tk && (cnt == duty))
            o = hi;
         else if (tk && (cnt == CNT_ZERO))
            o = !hi;
         chan_next = {o, !o, oe, oe_n};
      end
      else
      begin
         if (tk && (cnt == duty))
         begin
            unique case (code)
               ACT_COMP: o = !cur;
               ACT_CLR:  o = 1'b0;
               ACT_SET:  o = 1'b1;
               ACT_OFF:  o = cur;
            endcase
         end
         chan_next = {o, 1'b0, oe, 1'b0};
      end
   endfunction
   assign ch_a_d = chan_next(pwm_a, code_a, cnt_q, act_a_q, top_q, tick, pwm_out_a);
   assign ch_b_d = chan_next(pwm_b, code_b, cnt_q, act_b_q, top_q, tick, pwm_out_b);
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {pwm_out_a, pwm_out_a_n, pwm_out_a_oe, pwm_out_a_n_oe} <= 4'h0;
         {pwm_out_b, pwm_out_b_n, pwm_out_b_oe, pwm_out_b_n_oe} <= 4'h0;
      end
      else if (ce)
      begin
         {pwm_out_a, pwm_out_a_n, pwm_out_a_oe, pwm_out_a_n_oe} <= ch_a_d;
         {pwm_out_b, pwm_out_b_n, pwm_out_b_oe, pwm_out_b_n_oe} <= ch_b_d;
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   // count and flags come from the delayed side, control reads are direct
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_data <= REG_RST;
      else if (ce)
      begin
         rd_data <= REG_RST;
         if (rd_en)
         begin
            unique case (addr)
               REG_CTRL:   rd_data <= ctrl_q;
               REG_GEN:    rd_data <= gen_q;
               REG_DUTY_A: rd_data <= buf_a_q;
               REG_DUTY_B: rd_data <= buf_b_q;
               REG_TOP:    rd_data <= top_q;
               REG_COUNT:  rd_data <= cnt_s2_q;
               REG_FLAG:   rd_data <= flags_q;
               REG_MASK:   rd_data <= mask_q;
               REG_CFG:    rd_data <= cfg_q | (DATA_W'(pin_s[1]) << CF_LOCK);
               default:    rd_data <= REG_RST;
            endcase
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_duty_readback: assert property (
      (ce && wr_en && addr == REG_DUTY_A) ##1 (ce && rd_en && addr == REG_DUTY_A) |=> rd_data == $past(wr_data, 2))
      else $error("duty a read does not return last write");
   a_wrap_delay: assert property (
      (ce && ev_now[FL_WRAP]) ##1 ce [*2] |=> flags_q[FL_WRAP])
      else $error("wrap flag not set after sync delay");
   a_top_restart: assert property (
      (ce && tick && pwm_mode && at_top && !(wr_en && addr == REG_COUNT)) |=> cnt_q == CNT_ZERO)
      else $error("counter did not restart after top");
   a_count_step: assert property (
      (ce && tick && !at_top && !at_max && !(wr_en && addr == REG_COUNT)) |=> cnt_q == $past(cnt_q) + CNT_ONE)
      else $error("counter did not advance on tick");
   a_buffer_hold: assert property (
      (ce && pwm_a && !load) |=> act_a_q == $past(act_a_q))
      else $error("active duty changed away from top");
   a_normal_inv_off: assert property (
      (ce && !pwm_a) |=> !pwm_out_a_n_oe && !pwm_out_a_n)
      else $error("inverted output driven in normal mode");
   a_stop_no_tick: assert property (
      (ctrl_q[CC_DIV +: 4] == 4'h0) |-> !tick)
      else $error("tick while divider stopped");
   a_irq_gated: assert property (
      (ce && !(cfg_q[CF_GIE] && |(flags_q & mask_q))) |=> !irq_req)
      else $error("interrupt raised without flag and enables");
   a_static_high: assert property (
      (ce && pwm_a && code_a == ACT_CLR && act_a_q == top_q && top_q != CNT_ZERO) |=> pwm_out_a)
      else $error("output not held high at duty equal top");
   a_pair_compl: assert property (
      (ce && pwm_a && code_a == ACT_COMP) |=> pwm_out_a_n == !pwm_out_a && pwm_out_a_n_oe)
      else $error("complementary pair overlaps");
endmodule

// ===== sim/fcdpwm_load.sv
// load model for the pwm pins: pulled-low pins, high-time and overlap counters
`timescale 1ns/1ps
module fcdpwm_load
(
   input  wire logic        clk,
   input  wire logic        clr,
   input  wire logic [3:0]  pin,
   input  wire logic [3:0]  oe,
   output logic      [15:0] hi_a,
   output logic      [15:0] hi_an,
   output logic      [15:0] hi_b,
   output logic      [15:0] hi_bn,
   output logic      [15:0] clash
);
   logic [3:0] lvl;

   // undriven pins fall to the pull-down and never keep a stale level
   assign lvl = pin & oe;

   always_ff @(posedge clk)
   begin
      if (clr)
      begin
         hi_a  <= '0;
         hi_an <= '0;
         hi_b  <= '0;
         hi_bn <= '0;
         clash <= '0;
      end
      else
      begin
         hi_a  <= hi_a + 16'(lvl[3]);
         hi_an <= hi_an + 16'(lvl[2]);
         hi_b  <= hi_b + 16'(lvl[1]);
         hi_bn <= hi_bn + 16'(lvl[0]);
         // a driven pair at one level would short the half bridge
         if ((oe[3] & oe[2] & (pin[3] == pin[2])) | (oe[1] & oe[0] & (pin[1] == pin[0])))
            clash <= clash + 16'h0001;
      end
   end
endmodule

// ===== sim/fcdpwm_top_test.sv
// self-checking testbench for the fast counter dual pwm block
`timescale 1ns/1ps
module fcdpwm_top_test
   import fcdpwm_pkg::*;
();
   logic              clk, rst_b, ce, wr_en, rd_en, fclk, fclk_run, lock, clr, irq_req, ok;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data, rd_data, got;
   logic [3:0]        pin, oe;
   logic [15:0]       hi_a, hi_an, hi_b, hi_bn, clash, m;
   int                error_cnt, samples_checked, win;
   logic [1:0]        ca [5] = '{1, 1, 1, 2, 0};
   logic [1:0]        cb [5] = '{2, 3, 2, 3, 3};
   logic [3:0]        dv [5] = '{1, 3, 1, 1, 1};
   logic [7:0]        da [5] = '{3, 3, 0, 9, 3};
   logic [7:0]        db [5] = '{2, 2, 0, 9, 0};
   logic [15:0]       ea [5] = '{30, 30, 0, 100, 0};
   logic [15:0]       ean [5] = '{70, 70, 100, 0, 0};
   logic [15:0]       eb [5] = '{20, 80, 0, 0, 100};

   fcdpwm_top fcdpwm_top_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fast_periph_clock(fclk),
      .pll_lock_indicator(lock), .pwm_out_a(pin[3]), .pwm_out_a_oe(oe[3]), .pwm_out_a_n(pin[2]),
      .pwm_out_a_n_oe(oe[2]), .pwm_out_b(pin[1]), .pwm_out_b_oe(oe[1]), .pwm_out_b_n(pin[0]),
      .pwm_out_b_n_oe(oe[0]), .irq_req(irq_req));

   fcdpwm_load fcdpwm_load_inst (.clk(clk), .clr(clr), .pin(pin), .oe(oe), .hi_a(hi_a),
      .hi_an(hi_an), .hi_b(hi_b), .hi_bn(hi_bn), .clash(clash));

   // ************************************************************
   // clocks
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // fast clock stands still until enabled; period unrelated to clk
   initial
   begin
      fclk = 1'b0;
      forever #18.3 fclk = fclk_run ? ~fclk : 1'b0;
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD reg at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_cnt(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD count at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 got = rd_data;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      rd(a);
      chk_reg(got, e);
   endtask

   // write, then read in the very next cycle
   task automatic wrrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
      rd_en   <= 1'b1;
      @(posedge clk);
      rd_en   <= 1'b0;
      #1 chk_reg(rd_data, e);
   endtask

   // window is a whole number of periods, so phase does not matter
   task automatic window(input int n);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [7:0] ctl(input logic p, input logic [1:0] c, input logic [3:0] d);
      return (8'(p) << CC_PWM_A) | (8'(c) << CC_CODE_A) | 8'(d);
   endfunction

   function automatic logic [7:0] gen(input logic p, input logic [1:0] c);
      return (8'(p) << GC_PWM_B) | (8'(c) << GC_CODE_B);
   endfunction

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      error_cnt = 0;
      samples_checked = 0;
      rst_b = 1'b0;
      ce = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = '0;
      wr_data = '0;
      lock = 1'b0;
      clr = 1'b0;
      fclk_run = 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rdc(REG_CTRL, REG_RST);
      rdc(REG_TOP, TOP_RST);
      rdc(REG_FLAG, 8'h00);
      rdc(4'hF, 8'h00);
      wrrd(REG_CTRL, 8'hA5, 8'hA5);
      wrrd(REG_GEN, 8'h52, 8'h52 & GEN_BITS);
      wrrd(REG_DUTY_A, 8'h3C, 8'h3C);
      wrrd(REG_DUTY_B, 8'hC3, 8'hC3);
      wrrd(REG_TOP, 8'h7E, 8'h7E);
      // normal mode: toggle on a, clear on b, wrap at ff
      // b leaves pwm first, else its duty would sit in the buffer
      wr(REG_GEN, gen(1'b0, 2'h2));
      wr(REG_DUTY_A, 8'h10);
      wr(REG_DUTY_B, 8'h20);
      wr(REG_CTRL, ctl(1'b0, 2'h1, 4'h1));
      wr(REG_FLAG, FL_BITS);
      repeat (300) @(posedge clk);
      rdc(REG_FLAG, FL_BITS);
      chk_reg({4'h0, oe}, 8'h0A);
      wr(REG_MASK, FL_BITS);
      wr(REG_CFG, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk_reg({7'h00, irq_req}, 8'h00);
      wr(REG_CFG, 8'(1) << CF_GIE);
      repeat (3) @(posedge clk);
      #1 chk_reg({7'h00, irq_req}, 8'h01);
      wr(REG_CTRL, ctl(1'b0, 2'h1, 4'h0));
      repeat (4) @(posedge clk);
      wr(REG_FLAG, FL_BITS);
      repeat (20) @(posedge clk);
      #1 chk_reg({7'h00, irq_req}, 8'h00);
      rdc(REG_FLAG, 8'h00);
      // pwm mode, top 9: ten ticks a period
      wr(REG_TOP, 8'h09);
      // stopped count may sit above top; restart from zero
      wr(REG_COUNT, 8'h00);
      repeat (2) @(posedge clk);
      rdc(REG_COUNT, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         m = 16'h0001 << (dv[i] - 4'h1);
         win = 100 * int'(m);
         wr(REG_CTRL, ctl(1'b1, ca[i], dv[i]));
         wr(REG_GEN, gen(1'b1, cb[i]));
         wrrd(REG_DUTY_A, da[i], da[i]);
         wrrd(REG_DUTY_B, db[i], db[i]);
         repeat (win) @(posedge clk);
         wr(REG_FLAG, FL_BITS);
         window(win);
         chk_cnt(hi_a, ea[i] * m);
         chk_cnt(hi_an, ean[i] * m);
         chk_cnt(hi_b, eb[i] * m);
         chk_cnt(hi_bn, 16'h0000);
         chk_cnt(clash, 16'h0000);
         rdc(REG_FLAG, FL_BITS);
      end
      // fast clock: lock first, then select, counter idles while fast clock stands
      lock <= 1'b1;
      ok = 1'b0;
      for (int k = 0; k < 20 && !ok; k++)
      begin
         rd(REG_CFG);
         ok = (got[CF_LOCK] === 1'b1);
      end
      if (!ok)
      begin
         error_cnt++;
         final_report();
      end
      wr(REG_CFG, 8'(1) << CF_FAST);
      repeat (6) @(posedge clk);
      wr(REG_FLAG, FL_BITS);
      repeat (50) @(posedge clk);
      rdc(REG_FLAG, 8'h00);
      fclk_run <= 1'b1;
      repeat (200) @(posedge clk);
      rdc(REG_FLAG, FL_BITS);
      final_report();
   end
endmodule
